/* hw/dfx_defines.svh */
`ifndef DFX_DEFINES_SVH
`define DFX_DEFINES_SVH

// words of storage in the long-word memory behind port a
`define DFX_DEPTH 5'h10
// fill level at or below which an almost-empty flag goes low
`define DFX_AE_LEVEL 6'h04
// index of the last sub-transfer of a long word, word size
`define DFX_WORD_LAST 2'h1
// index of the last sub-transfer of a long word, byte size
`define DFX_BYTE_LAST 2'h3
// number of entries held by the output buffer
`define DFX_BUF_FULL 2'h2
// clocks after reset release before the straps are caught
`define DFX_CAP_WAIT 2'h2
// count of synchronised pin bits
`define DFX_PIN_W 52

`endif

/* hw/dfx_pkg.sv */
`default_nettype none
package dfx_pkg;
  // one 36-bit long word of port a
  typedef logic [35:0] dfx_long_t;
  // one 18-bit transfer of port b
  typedef logic [17:0] dfx_word_t;
  // fill count of a fifo
  typedef logic [4:0] dfx_cnt_t;
  // memory pointer
  typedef logic [3:0] dfx_ptr_t;
  // sub-transfer index inside a long word
  typedef logic [1:0] dfx_sub_t;
endpackage
`default_nettype wire

/* hw/dfx_flags.sv */
// Summary of operation
// - fall_through_timing: fifo1 ready rises next port-a cycle
// - sized port b: last sub-read frees space
// - standard: fifo1 full released next port-a cycle
// - fall_through_timing: fifo2 ready rises next port-c cycle
// - sized port c: last sub-write drops ready
// - standard: fifo2 full released next port-c cycle
// - sized port c: last sub-write asserts full
// - fifo1 almost-empty rises next port-b cycle
// - sized port b: last sub-read lowers almost-empty
// - fifo2 almost-empty rises next port-a cycle
// - sized port c: last sub-write counts for fifo2
// - output-register word counts as removed
// - writes ignored while full flag low
`timescale 1ns/1ps
`include "dfx_defines.svh"
`default_nettype none
module dfx_flags (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic port_a_clock,
  input wire logic port_b_clock,
  input wire logic port_c_clock,
  input wire logic port_a_chip_select_n,
  input wire logic port_a_direction,
  input wire logic port_a_mailbox_select,
  input wire logic port_a_transfer_gate,
  input wire logic [35:0] port_a_data,
  input wire logic port_b_chip_select_n,
  input wire logic port_b_mailbox_select,
  input wire logic port_b_read_gate,
  input wire logic port_b_byte_size,
  input wire logic port_c_mailbox_select,
  input wire logic port_c_write_gate,
  input wire logic port_c_byte_size,
  input wire logic endian_select,
  input wire logic fall_through_timing,
  output logic fifo1_input_ready,
  output logic fifo1_full_n,
  output logic fifo2_input_ready,
  output logic fifo2_full_n,
  output logic fifo1_almost_empty_n,
  output logic fifo2_almost_empty_n,
  output logic [17:0] port_b_data
);

  // raw pin vector, all from outside this clock
  logic [`DFX_PIN_W-1:0] pins_raw;
  // first and second synchroniser stages
  logic [`DFX_PIN_W-1:0] sync1_r;
  logic [`DFX_PIN_W-1:0] sync2_r;
  // previous port clock levels for edge detection
  logic [2:0] clk_prev_r;
  // storage for fifo1 long words
  dfx_pkg::dfx_long_t mem [0:15];

  assign pins_raw = {port_a_clock, port_b_clock, port_c_clock, port_a_chip_select_n,
    port_a_direction, port_a_mailbox_select, port_a_transfer_gate,
    port_b_chip_select_n, port_b_mailbox_select, port_b_read_gate, port_b_byte_size,
    port_c_mailbox_select, port_c_write_gate, port_c_byte_size, endian_select,
    fall_through_timing, port_a_data};

  // two-flop synchroniser, only stage two is read
  // no reset, so the pipe holds the straps at release
  always_ff @(posedge sys_clk)
  begin
    sync1_r <= pins_raw;
    sync2_r <= sync1_r;
  end

  // previous port clock levels
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      clk_prev_r <= 3'h0;
    else
      clk_prev_r <= sync2_r[51:49];
  end

  // synchronised pin names
  logic a_cs_n, a_dir, a_mbx, a_gate, b_cs_n, b_mbx, b_gate, b_size;
  logic c_mbx, c_gate, c_size, endian_s, fall_through_timing_s;
  dfx_pkg::dfx_long_t a_data;
  assign {a_cs_n, a_dir, a_mbx, a_gate} = sync2_r[48:45];
  assign {b_cs_n, b_mbx, b_gate, b_size} = sync2_r[44:41];
  assign {c_mbx, c_gate, c_size, endian_s, fall_through_timing_s} = sync2_r[40:36];
  assign a_data = sync2_r[35:0];

  // state and next values
  logic [1:0] cap_cnt_r, cap_cnt_nxt;
  logic endian_r, endian_nxt, fall_through_timing_r, fall_through_timing_nxt;
  dfx_pkg::dfx_ptr_t wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  dfx_pkg::dfx_cnt_t cnt1_r, cnt1_nxt, cnt2_r, cnt2_nxt;
  dfx_pkg::dfx_long_t buf0_r, buf0_nxt, buf1_r, buf1_nxt;
  logic [1:0] buf_cnt_r, buf_cnt_nxt;
  dfx_pkg::dfx_sub_t b_sub_r, b_sub_nxt, c_sub_r, c_sub_nxt;
  dfx_pkg::dfx_word_t b_data_r, b_data_nxt;
  logic f1_space_r, f1_space_nxt, f2_space_r, f2_space_nxt;
  logic f1_ae_n_r, f1_ae_n_nxt, f2_ae_n_r, f2_ae_n_nxt;

  // event terms
  logic live, a_edge, b_edge, c_edge;
  logic a_wr1, a_rd2, b_rd, b_last, pop_buf, fill, c_wr, c_last, c_commit;
  dfx_pkg::dfx_sub_t b_last_idx, c_last_idx, b_idx;
  logic [5:0] tot1, lvl1;
  dfx_pkg::dfx_word_t b_sel;

  // edges seen only after the straps are caught
  assign live = (cap_cnt_r == `DFX_CAP_WAIT);
  assign a_edge = live & sync2_r[51] & ~clk_prev_r[2];
  assign b_edge = live & sync2_r[50] & ~clk_prev_r[1];
  assign c_edge = live & sync2_r[49] & ~clk_prev_r[0];

  // fifo1 write only with flag high
  assign a_wr1 = a_edge & ~a_cs_n & a_dir & ~a_mbx & a_gate & f1_space_r
    & (cnt1_r != `DFX_DEPTH);
  assign a_rd2 = a_edge & ~a_cs_n & ~a_dir & ~a_mbx & a_gate & (cnt2_r != 5'h00);
  assign b_rd = b_edge & ~b_cs_n & ~b_mbx & b_gate & (buf_cnt_r != 2'h0);
  assign b_last_idx = b_size ? `DFX_BYTE_LAST : `DFX_WORD_LAST;
  // last sub-read frees the long word
  assign b_last = (b_sub_r == b_last_idx);
  assign pop_buf = b_rd & b_last;
  // memory feeds buffer while buffer has room
  assign fill = (cnt1_r != 5'h00) & (buf_cnt_r != `DFX_BUF_FULL);
  // fifo2 write at port c, ignored while full
  assign c_wr = c_edge & ~c_mbx & c_gate & f2_space_r;
  assign c_last_idx = c_size ? `DFX_BYTE_LAST : `DFX_WORD_LAST;
  assign c_last = (c_sub_r == c_last_idx);
  // long word counted on its last sub-write
  assign c_commit = c_wr & c_last & (cnt2_r != `DFX_DEPTH);

  // head of buffer is the output register
  assign tot1 = {1'b0, cnt1_r} + {4'h0, buf_cnt_r} - {5'h00, pop_buf};
  assign lvl1 = (tot1 != 6'h00) ? tot1 - 6'h01 : 6'h00;

  // sub-word pick, order set by the endian strap
  always_comb
  begin
    b_idx = endian_r ? b_sub_r : (b_last_idx - b_sub_r);
    b_sel = '0;
    if (!b_size)
      b_sel = b_idx[0] ? buf0_r[17:0] : buf0_r[35:18];
    else
    begin
      unique case (b_idx)
        2'h0: b_sel = {9'h000, buf0_r[35:27]};
        2'h1: b_sel = {9'h000, buf0_r[26:18]};
        2'h2: b_sel = {9'h000, buf0_r[17:9]};
        2'h3: b_sel = {9'h000, buf0_r[8:0]};
      endcase
    end
  end

  // strap capture after reset release
  always_comb
  begin
    cap_cnt_nxt = cap_cnt_r;
    endian_nxt = endian_r;
    fall_through_timing_nxt = fall_through_timing_r;
    if (!live)
    begin
      cap_cnt_nxt = cap_cnt_r + 2'h1;
      endian_nxt = endian_s;
      fall_through_timing_nxt = fall_through_timing_s;
    end
  end

  // fifo1 pointers, count and output buffer
  always_comb
  begin
    wr_ptr_nxt = wr_ptr_r + {3'h0, a_wr1};
    rd_ptr_nxt = rd_ptr_r + {3'h0, fill};
    cnt1_nxt = cnt1_r + {4'h0, a_wr1} - {4'h0, fill};
    buf0_nxt = buf0_r;
    buf1_nxt = buf1_r;
    buf_cnt_nxt = buf_cnt_r + {1'b0, fill} - {1'b0, pop_buf};
    if (pop_buf && fill && buf_cnt_r == 2'h1)
      buf0_nxt = mem[rd_ptr_r];
    else if (pop_buf)
      buf0_nxt = buf1_r;
    else if (fill && buf_cnt_r == 2'h0)
      buf0_nxt = mem[rd_ptr_r];
    if (fill && !(pop_buf && buf_cnt_r == 2'h1) && buf_cnt_r != 2'h0)
      buf1_nxt = mem[rd_ptr_r];
    // sub-read counter wraps on the last sub-read
    b_sub_nxt = b_sub_r;
    if (b_rd)
      b_sub_nxt = b_last ? 2'h0 : b_sub_r + 2'h1;
    b_data_nxt = b_rd ? b_sel : b_data_r;
  end

  // fifo2 count and sub-write counter
  always_comb
  begin
    cnt2_nxt = cnt2_r + {4'h0, c_commit} - {4'h0, a_rd2};
    c_sub_nxt = c_sub_r;
    if (c_wr)
      c_sub_nxt = c_last ? 2'h0 : c_sub_r + 2'h1;
  end

  // flags, each moved only on its own port edge
  always_comb
  begin
    f1_space_nxt = f1_space_r;
    f2_space_nxt = f2_space_r;
    f1_ae_n_nxt = f1_ae_n_r;
    f2_ae_n_nxt = f2_ae_n_r;
    // space seen at next port-a edge
    if (a_edge)
      f1_space_nxt = (cnt1_nxt != `DFX_DEPTH);
    // set low by the filling sub-write
    if (c_edge)
      f2_space_nxt = (cnt2_nxt != `DFX_DEPTH);
    // level judged at each port-b edge
    if (b_edge)
      f1_ae_n_nxt = (lvl1 > `DFX_AE_LEVEL);
    // level judged at each port-a edge
    if (a_edge)
      f2_ae_n_nxt = ({1'b0, cnt2_nxt} > `DFX_AE_LEVEL);
  end

  // memory write, no reset on storage
  always_ff @(posedge sys_clk)
  begin
    if (a_wr1)
      mem[wr_ptr_r] <= a_data;
  end

  // register all state
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cap_cnt_r <= 2'h0;
      endian_r <= 1'b0;
      fall_through_timing_r <= 1'b0;
      wr_ptr_r <= 4'h0;
      rd_ptr_r <= 4'h0;
      cnt1_r <= 5'h00;
      cnt2_r <= 5'h00;
      buf0_r <= 36'h000000000;
      buf1_r <= 36'h000000000;
      buf_cnt_r <= 2'h0;
      b_sub_r <= 2'h0;
      c_sub_r <= 2'h0;
      b_data_r <= 18'h00000;
      f1_space_r <= 1'b0;
      f2_space_r <= 1'b0;
      f1_ae_n_r <= 1'b0;
      f2_ae_n_r <= 1'b0;
    end
    else
    begin
      cap_cnt_r <= cap_cnt_nxt;
      endian_r <= endian_nxt;
      fall_through_timing_r <= fall_through_timing_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt1_r <= cnt1_nxt;
      cnt2_r <= cnt2_nxt;
      buf0_r <= buf0_nxt;
      buf1_r <= buf1_nxt;
      buf_cnt_r <= buf_cnt_nxt;
      b_sub_r <= b_sub_nxt;
      c_sub_r <= c_sub_nxt;
      b_data_r <= b_data_nxt;
      f1_space_r <= f1_space_nxt;
      f2_space_r <= f2_space_nxt;
      f1_ae_n_r <= f1_ae_n_nxt;
      f2_ae_n_r <= f2_ae_n_nxt;
    end
  end

  // flag pins per timing mode, unused pin parked inactive
  assign fifo1_input_ready = fall_through_timing_r & f1_space_r;
  assign fifo1_full_n = fall_through_timing_r | f1_space_r;
  assign fifo2_input_ready = fall_through_timing_r & f2_space_r;
  assign fifo2_full_n = fall_through_timing_r | f2_space_r;
  assign fifo1_almost_empty_n = f1_ae_n_r;
  assign fifo2_almost_empty_n = f2_ae_n_r;
  assign port_b_data = b_data_r;

endmodule
`default_nettype wire

/* tb/dfx_port_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dfx_port_model (
  output logic port_a_clock,
  output logic port_b_clock,
  output logic port_c_clock
);
  // unrelated free-running port clocks, each phase over 6 sys_clk
  initial
  begin
    port_a_clock = 1'b0;
    port_b_clock = 1'b0;
    port_c_clock = 1'b0;
    fork
      forever #630 port_a_clock = ~port_a_clock;
      forever #710 port_b_clock = ~port_b_clock;
      forever #667 port_c_clock = ~port_c_clock;
    join
  end
endmodule
`default_nettype wire

/* tb/dfx_flags_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module dfx_flags_sva (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic port_a_clock,
  input wire logic port_b_clock,
  input wire logic port_c_clock,
  input wire logic fall_through_timing,
  input wire logic fifo1_input_ready,
  input wire logic fifo1_full_n,
  input wire logic fifo2_input_ready,
  input wire logic fifo2_full_n,
  input wire logic fifo1_almost_empty_n,
  input wire logic fifo2_almost_empty_n,
  input wire logic [17:0] port_b_data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // port clock high now or in the last two cycles
  sequence near(c);
    c || $past(c) || $past(c, 2);
  endsequence
  a_std_rdy_low: assert property (!fall_through_timing
    |-> !fifo1_input_ready && !fifo2_input_ready)
    else $error("ready high in standard mode");
  a_f1_full_edge: assert property (!fall_through_timing && $changed(fifo1_full_n)
    |-> near(port_a_clock))
    else $error("fifo1 full moved off port a edge");
  a_f2_full_edge: assert property (!fall_through_timing && $changed(fifo2_full_n)
    |-> near(port_c_clock))
    else $error("fifo2 full moved off port c edge");
  a_f1_rdy_edge: assert property ($changed(fifo1_input_ready) |-> near(port_a_clock))
    else $error("fifo1 ready moved off port a edge");
  a_f2_rdy_edge: assert property ($changed(fifo2_input_ready) |-> near(port_c_clock))
    else $error("fifo2 ready moved off port c edge");
  a_f1_ae_edge: assert property ($changed(fifo1_almost_empty_n) |-> near(port_b_clock))
    else $error("fifo1 almost empty off port b edge");
  a_f2_ae_edge: assert property ($changed(fifo2_almost_empty_n) |-> near(port_a_clock))
    else $error("fifo2 almost empty off port a edge");
  a_bdata_edge: assert property ($changed(port_b_data) |-> near(port_b_clock))
    else $error("read data moved off port b edge");
endmodule
bind dfx_flags dfx_flags_sva chk (.sys_clk, .nrst, .port_a_clock, .port_b_clock, .port_c_clock,
  .fall_through_timing, .fifo1_input_ready, .fifo1_full_n, .fifo2_input_ready, .fifo2_full_n,
  .fifo1_almost_empty_n, .fifo2_almost_empty_n, .port_b_data);
`default_nettype wire

/* tb/dfx_flags_bench.sv */
`timescale 1ns/1ps
`include "dfx_defines.svh"
`default_nettype none
`define CHK(a, b) \
  begin \
    compares++; \
    if ((a) !== (b)) \
    begin \
      failures++; \
      $display("mismatch t=%0t got=%h exp=%h", $time, a, b); \
    end \
  end
module dfx_flags_bench;
  int failures = 0;
  int compares = 0;
  int n;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] go = 3'h0;
  logic port_a_direction = 1'b1;
  logic [35:0] port_a_data = 36'h0;
  logic port_b_byte_size = 1'b0;
  logic port_c_byte_size = 1'b0;
  logic fall_through_timing = 1'b0;
  logic port_a_mailbox_select = 1'b0;
  logic port_b_mailbox_select = 1'b0;
  logic port_c_mailbox_select = 1'b0;
  logic endian_select = 1'b1;
  wire logic port_a_transfer_gate = go[0];
  wire logic port_a_chip_select_n = !go[0];
  wire logic port_b_read_gate = go[1];
  wire logic port_b_chip_select_n = !go[1];
  wire logic port_c_write_gate = go[2];
  wire logic port_a_clock, port_b_clock, port_c_clock;
  wire logic fifo1_input_ready, fifo1_full_n, fifo2_input_ready, fifo2_full_n;
  wire logic fifo1_almost_empty_n, fifo2_almost_empty_n;
  wire logic [17:0] port_b_data;
  wire logic [2:0] pk = {port_c_clock, port_b_clock, port_a_clock};
  dfx_port_model pm (.port_a_clock, .port_b_clock, .port_c_clock);
  dfx_flags uut (.sys_clk, .nrst, .port_a_clock, .port_b_clock, .port_c_clock,
    .port_a_chip_select_n, .port_a_direction, .port_a_mailbox_select, .port_a_transfer_gate,
    .port_a_data, .port_b_chip_select_n, .port_b_mailbox_select, .port_b_read_gate,
    .port_b_byte_size, .port_c_mailbox_select, .port_c_write_gate, .port_c_byte_size,
    .endian_select, .fall_through_timing, .fifo1_input_ready, .fifo1_full_n,
    .fifo2_input_ready, .fifo2_full_n, .fifo1_almost_empty_n, .fifo2_almost_empty_n,
    .port_b_data);
  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // bounded wait for a port clock level
  task automatic wt(input int p, input logic v);
    int k;
    k = 0;
    while (pk[p] !== v)
    begin
      @(posedge sys_clk);
      #1 k++;
      if (k > 200)
      begin
        failures++;
        report_and_stop;
      end
    end
  endtask
  // one transfer on port p, held across one port clock rise
  task automatic xf(input int p, input logic d);
    wt(p, 1'b0);
    port_a_direction = d;
    go[p] = 1'b1;
    wt(p, 1'b1);
    repeat (4) @(posedge sys_clk);
    #1 go = 3'h0;
  endtask
  task automatic pause;
    repeat (30) @(posedge sys_clk);
    #1;
  endtask
  task automatic rst(input logic ft, input logic sz);
    go = 3'h0;
    nrst = 1'b0;
    fall_through_timing = ft;
    port_b_byte_size = sz;
    port_c_byte_size = sz;
    repeat (2) @(posedge sys_clk);
    #1 nrst = 1'b1;
  endtask
  task automatic t_std_f1;
    pause;
    `CHK(fifo1_full_n, 1'b1) // space after first edge
    for (n = 1; n <= 6; n++)
    begin
      port_a_data = {n[17:0], ~n[17:0]};
      xf(0, 1'b1);
      pause;
      if (n >= 5) `CHK(fifo1_almost_empty_n, n > 5) // level edge
    end
    xf(1, 1'b0);
    `CHK(port_b_data, 18'h00001) // high half first
    xf(1, 1'b0);
    `CHK(port_b_data, 18'h3FFFE) // low half last
    pause;
    `CHK(fifo1_almost_empty_n, 1'b0) // low after last read
    n = 0;
    while (fifo1_full_n === 1'b1 && n < 40)
    begin
      xf(0, 1'b1);
      n++;
    end
    `CHK(n, `DFX_DEPTH + `DFX_BUF_FULL - 5) // full at capacity
    xf(1, 1'b0);
    pause;
    `CHK(fifo1_full_n, 1'b0) // half word frees nothing
    xf(1, 1'b0);
    pause;
    `CHK(fifo1_full_n, 1'b1) // full released
    $display("test fifo1 standard done");
  endtask
  task automatic t_std_f2;
    n = 0;
    while (fifo2_full_n === 1'b1 && n < 99)
    begin
      xf(2, 1'b0);
      n++;
    end
    `CHK(n, `DFX_DEPTH * (`DFX_WORD_LAST + 1)) // full on last word
    `CHK(fifo2_almost_empty_n, 1'b1) // above level
    xf(0, 1'b0);
    pause;
    `CHK(fifo2_full_n, 1'b1) // full released
    $display("test fifo2 standard done");
  endtask
  task automatic t_fall_through_timing;
    pause;
    `CHK(fifo1_input_ready, 1'b1) // ready after first edge
    port_a_data = 36'h123456789;
    n = 0;
    while (fifo1_input_ready === 1'b1 && n < 40)
    begin
      xf(0, 1'b1);
      n++;
    end
    `CHK(n, `DFX_DEPTH + `DFX_BUF_FULL) // ready low at capacity
    for (n = 1; n <= 4; n++)
    begin
      xf(1, 1'b0);
      if (n == 1) `CHK(port_b_data, 18'h00024) // top byte first
      pause;
      `CHK(fifo1_input_ready, n == 4) // ready after last byte
    end
    n = 0;
    while (fifo2_input_ready === 1'b1 && n < 99)
    begin
      xf(2, 1'b0);
      n++;
    end
    `CHK(n, `DFX_DEPTH * (`DFX_BYTE_LAST + 1)) // ready drops on last byte
    xf(0, 1'b0);
    pause;
    `CHK(fifo2_input_ready, 1'b1) // ready rises again
    $display("test fall through done");
  endtask
  task automatic t_little;
    endian_select = 1'b0;
    rst(1'b0, 1'b0);
    pause;
    port_a_data = 36'h123456789;
    xf(0, 1'b1);
    pause;
    xf(1, 1'b0);
    `CHK(port_b_data, 18'h16789) // low half first
    xf(1, 1'b0);
    `CHK(port_b_data, 18'h048D1) // high half last
    $display("test little endian done");
  endtask
  initial
  begin
    rst(1'b0, 1'b0);
    t_std_f1;
    t_std_f2;
    rst(1'b1, 1'b1);
    t_fall_through_timing;
    t_little;
    report_and_stop;
  end
endmodule
`default_nettype wire
